// ==== design/rplp_dev.sv ====
// Attached device end: D-state holder and link negotiation
module rplp_dev (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        cmd_enable,   // Mem/IO/master enable set
  input  wire logic        wake_req,     // Device wants L1 exit
  input  wire logic        pme_req,      // Device PME request
  output logic [2:0]       dstate,
  output logic             active,       // D0 active
  output logic             ctx_lost,     // Reinit needed
  output logic [9:0]       power_limit,
  rplp_link_if.dev         link
);
  typedef struct packed {
    logic [2:0] dstate;
    logic       active;
    logic       ctx_lost;
    logic [9:0] limit;
    logic       l1_req;
    logic       l23_ack;
    logic       l1_exit;
    logic       pme;
  } rplp_dev_st_t;

  rplp_dev_st_t st_ff;
  rplp_dev_st_t nxt_st;
  localparam logic [9:0] DEF_LIMIT = 10'h00A; // 10W default

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.l1_req  = 1'b0;
    nxt_st.l23_ack = 1'b0;
    nxt_st.l1_exit = 1'b0;
    nxt_st.pme     = 1'b0;
    // Leaves uninitialized D0 on enable
    if (st_ff.dstate == rplp_pkg::RPLP_D0 && cmd_enable)
      nxt_st.active = 1'b1;
    if (link.msg_vld) begin
      case (link.msg_code)
        rplp_pkg::RPLP_MSG_DSET: begin
          nxt_st.dstate = link.msg_data[2:0];
          if (link.msg_data[2:0] >= rplp_pkg::RPLP_D3HOT)
            nxt_st.ctx_lost = 1'b1;
          if (link.msg_data[2:0] == rplp_pkg::RPLP_D0 && st_ff.ctx_lost)
            nxt_st.active = 1'b0;   // Must reinit
          if (link.msg_data[2:0] == rplp_pkg::RPLP_D0 && !st_ff.ctx_lost)
            nxt_st.active = 1'b1;   // Context kept
        end
        rplp_pkg::RPLP_MSG_LIMIT: nxt_st.limit = link.msg_data;
        rplp_pkg::RPLP_MSG_OFF:   nxt_st.l23_ack = 1'b1;
        default: ;
      endcase
    end
    // Negotiate L1 while in a low D-state
    if (st_ff.dstate != rplp_pkg::RPLP_D0 && link.link_up && !link.msg_vld)
      nxt_st.l1_req = 1'b1;
    if (st_ff.dstate != rplp_pkg::RPLP_D0) nxt_st.active = 1'b0;
    if (wake_req) nxt_st.l1_exit = 1'b1;
    // PME and L1 exit (wake_req) may be initiated in any D-state
    if (pme_req) nxt_st.pme = 1'b1;
    if (link.training && st_ff.ctx_lost && cmd_enable) begin
      nxt_st.ctx_lost = 1'b0; // Reinit done
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff       <= '0;
      st_ff.limit <= DEF_LIMIT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dstate          = st_ff.dstate;
  assign active          = st_ff.active;
  assign ctx_lost        = st_ff.ctx_lost;
  assign power_limit     = st_ff.limit;
  assign link.l1_req     = st_ff.l1_req;
  assign link.l23_ack    = st_ff.l23_ack;
  assign link.l1_exit_dn = st_ff.l1_exit;
  assign link.pme        = st_ff.pme;
endmodule : rplp_dev

// ==== design/rplp_link_if.sv ====
// Link between root port and attached device
interface rplp_link_if;
  logic                  msg_vld;   // One-cycle message pulse
  rplp_pkg::rplp_msg_t   msg_code;
  logic [9:0]            msg_data;
  logic                  training;  // Port training the link
  logic                  link_up;   // Port link in L0
  logic                  l1_exit_dn;  // Device requests L1 exit
  logic                  l1_req;    // Device asks for L1
  logic                  l23_ack;   // Device ready for power off
  logic                  pme;       // Device PME pulse

  modport port (
    output msg_vld, msg_code, msg_data, training, link_up,
    input  l1_exit_dn, l1_req, l23_ack, pme
  );
  modport dev (
    input  msg_vld, msg_code, msg_data, training, link_up,
    output l1_exit_dn, l1_req, l23_ack, pme
  );
endinterface : rplp_link_if

// ==== design/rplp_pkg.sv ====
package rplp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STAT   = 8'h04;
  localparam logic [7:0] REG_LIMIT  = 8'h08;
  localparam logic [7:0] REG_DSTATE = 8'h0C;
  localparam logic [7:0] REG_LAT    = 8'h10;

  // Control field positions
  localparam int CTRL_ASPM_LO    = 0;   // Two bits, read as zero
  localparam int CTRL_CCLK       = 2;   // Common clock configuration
  localparam int CTRL_SCLK       = 3;   // Slot clock configuration
  localparam int CTRL_RETRAIN    = 4;   // Write-one pulse
  localparam int CTRL_PWR_OFF    = 5;   // Request L2/L3 Ready
  localparam int CTRL_VAUX       = 6;   // Aux power present
  localparam int CTRL_PWR_ON     = 7;   // Power and clock restored
  localparam int CTRL_L1_EXIT    = 8;   // Upstream exit request

  // Exit latency encodings (short with common clock)
  localparam logic [2:0] L0S_LAT_COMMON = 3'h2;
  localparam logic [2:0] L0S_LAT_INDEP  = 3'h5;
  localparam logic [2:0] L1_LAT_COMMON  = 3'h1;
  localparam logic [2:0] L1_LAT_INDEP   = 3'h3;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [1:0]  ASPM_OFF  = 2'h0;

  // Device power states
  typedef enum logic [2:0] {
    RPLP_D0     = 3'h0,
    RPLP_D1     = 3'h1,
    RPLP_D2     = 3'h2,
    RPLP_D3HOT  = 3'h3,
    RPLP_D3COLD = 3'h4
  } rplp_dstate_t;

  // Link power states
  typedef enum logic [2:0] {
    RPLP_L0      = 3'h0,
    RPLP_L1      = 3'h1,
    RPLP_L23RDY  = 3'h2,
    RPLP_L2      = 3'h3,
    RPLP_L3      = 3'h4,
    RPLP_LTRAIN  = 3'h5
  } rplp_lstate_t;

  // Message codes on the link
  typedef enum logic [1:0] {
    RPLP_MSG_NONE  = 2'h0,
    RPLP_MSG_DSET  = 2'h1,
    RPLP_MSG_LIMIT = 2'h2,
    RPLP_MSG_OFF   = 2'h3
  } rplp_msg_t;

  localparam int LIMIT_W = 10;
  localparam logic [3:0] TRAIN_CYCLES = 4'h8;

endpackage : rplp_pkg

// ==== design/rplp_port.sv ====
// Root port link power manager with AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
module rplp_port (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  rplp_link_if.port        link
);
  typedef struct packed {
    logic                  wr_pend;
    logic [7:0]            wr_addr;
    logic [31:0]           rdata;
    logic [1:0]            aspm;      // Always ASPM_OFF
    logic                  cclk;
    logic                  sclk;
    logic                  vaux;
    logic [9:0]            limit;
    rplp_pkg::rplp_dstate_t dstate;
    rplp_pkg::rplp_lstate_t lstate;
    logic                  msg_vld;
    rplp_pkg::rplp_msg_t   msg_code;
    logic [9:0]            msg_data;
    logic                  train_go;
    logic                  pme_seen;
  } rplp_port_st_t;

  rplp_port_st_t st_ff;
  rplp_port_st_t nxt_st;
  logic          train_done;
  logic          rd_req;
  logic [2:0]    l0s_lat;
  logic [2:0]    l1_lat;
  logic [31:0]   wd;

  ////////////////////////////////////////////////////////////////////////////
  rplp_train u_train (
    .hclk    (hclk),
    .hresetn (hresetn),
    .start   (st_ff.train_go),
    .done    (train_done)
  );

  // Latency follows common clock bit
  assign l0s_lat = st_ff.cclk ? rplp_pkg::L0S_LAT_COMMON
                              : rplp_pkg::L0S_LAT_INDEP;
  assign l1_lat  = st_ff.cclk ? rplp_pkg::L1_LAT_COMMON
                              : rplp_pkg::L1_LAT_INDEP;
  assign rd_req  = hsel && htrans[1] && !hwrite;
  assign wd      = hwdata;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave and link power state machine
  always_comb begin
    nxt_st          = st_ff;
    nxt_st.msg_vld  = 1'b0;
    nxt_st.msg_code = rplp_pkg::RPLP_MSG_NONE;
    nxt_st.train_go = 1'b0;
    nxt_st.aspm     = rplp_pkg::ASPM_OFF;
    nxt_st.wr_pend  = hsel && htrans[1] && hwrite;
    nxt_st.wr_addr  = haddr;
    if (link.pme) nxt_st.pme_seen = 1'b1;

    // Read data registered in address phase, zero-wait answer
    nxt_st.rdata = rplp_pkg::ZERO_WORD;
    if (rd_req) begin
      case (haddr)
        rplp_pkg::REG_CTRL: begin
          nxt_st.rdata[rplp_pkg::CTRL_ASPM_LO +: 2] = st_ff.aspm;
          nxt_st.rdata[rplp_pkg::CTRL_CCLK] = st_ff.cclk;
          nxt_st.rdata[rplp_pkg::CTRL_SCLK] = st_ff.sclk;
          nxt_st.rdata[rplp_pkg::CTRL_VAUX] = st_ff.vaux;
        end
        rplp_pkg::REG_STAT: begin
          nxt_st.rdata[2:0] = st_ff.lstate;
          nxt_st.rdata[4]   = st_ff.pme_seen;
          nxt_st.pme_seen   = link.pme; // Set wins over read-clear
        end
        rplp_pkg::REG_LIMIT:  nxt_st.rdata[9:0] = st_ff.limit;
        rplp_pkg::REG_DSTATE: nxt_st.rdata[2:0] = st_ff.dstate;
        rplp_pkg::REG_LAT: begin
          nxt_st.rdata[2:0] = l0s_lat;
          nxt_st.rdata[6:4] = l1_lat;
          // Bit 8: ASPM capability, hard zero
        end
        default: nxt_st.rdata = rplp_pkg::ZERO_WORD;
      endcase
    end

    // Writes in data phase
    if (st_ff.wr_pend) begin
      case (st_ff.wr_addr)
        rplp_pkg::REG_CTRL: begin
          // ASPM bits discarded on purpose
          nxt_st.cclk = wd[rplp_pkg::CTRL_CCLK];
          nxt_st.sclk = wd[rplp_pkg::CTRL_SCLK];
          nxt_st.vaux = wd[rplp_pkg::CTRL_VAUX];
          if (wd[rplp_pkg::CTRL_RETRAIN] &&
              st_ff.lstate == rplp_pkg::RPLP_L0) begin
            nxt_st.lstate   = rplp_pkg::RPLP_LTRAIN;
            nxt_st.train_go = 1'b1;
          end
          if (wd[rplp_pkg::CTRL_L1_EXIT] &&
              st_ff.lstate == rplp_pkg::RPLP_L1) begin
            nxt_st.lstate = rplp_pkg::RPLP_L0;
          end
          if (wd[rplp_pkg::CTRL_PWR_OFF] &&
              st_ff.lstate != rplp_pkg::RPLP_L2 &&
              st_ff.lstate != rplp_pkg::RPLP_L3) begin
            // Turn-off handshake toward L2/L3 Ready
            nxt_st.msg_vld  = 1'b1;
            nxt_st.msg_code = rplp_pkg::RPLP_MSG_OFF;
          end
          if (wd[rplp_pkg::CTRL_PWR_ON] &&
              (st_ff.lstate == rplp_pkg::RPLP_L2 ||
               st_ff.lstate == rplp_pkg::RPLP_L3)) begin
            // Full reinit after power returns
            nxt_st.lstate   = rplp_pkg::RPLP_LTRAIN;
            nxt_st.train_go = 1'b1;
            nxt_st.dstate   = rplp_pkg::RPLP_D0;
          end
        end
        rplp_pkg::REG_LIMIT: begin
          nxt_st.limit    = wd[9:0];
          nxt_st.msg_vld  = 1'b1;
          nxt_st.msg_code = rplp_pkg::RPLP_MSG_LIMIT;
          nxt_st.msg_data = wd[9:0];
        end
        rplp_pkg::REG_DSTATE: begin
          if (wd[2:0] <= rplp_pkg::RPLP_D3COLD) begin
            nxt_st.dstate   = rplp_pkg::rplp_dstate_t'(wd[2:0]);
            nxt_st.msg_vld  = 1'b1;
            nxt_st.msg_code = rplp_pkg::RPLP_MSG_DSET;
            nxt_st.msg_data = {7'h00, wd[2:0]};
          end
        end
        default: ;
      endcase
    end

    // Link state inferred from device activity, never from ASPM
    case (st_ff.lstate)
      rplp_pkg::RPLP_L0: begin
        if (link.l1_req && st_ff.dstate != rplp_pkg::RPLP_D0)
          nxt_st.lstate = rplp_pkg::RPLP_L1;
        if (link.l23_ack)
          nxt_st.lstate = rplp_pkg::RPLP_L23RDY;
      end
      rplp_pkg::RPLP_L1: begin
        if (link.l1_exit_dn) nxt_st.lstate = rplp_pkg::RPLP_L0;
        if (link.l23_ack)    nxt_st.lstate = rplp_pkg::RPLP_L23RDY;
      end
      rplp_pkg::RPLP_L23RDY:
        nxt_st.lstate = st_ff.vaux ? rplp_pkg::RPLP_L2 : rplp_pkg::RPLP_L3;
      rplp_pkg::RPLP_L2: ; // No in-band wake
      rplp_pkg::RPLP_L3: ;
      rplp_pkg::RPLP_LTRAIN:
        if (train_done) nxt_st.lstate = rplp_pkg::RPLP_L0;
      default: nxt_st.lstate = rplp_pkg::RPLP_L0;
    endcase
  end

  // Reset lands in L0, ASPM off
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff        <= '0;
      st_ff.dstate <= rplp_pkg::RPLP_D0;
      st_ff.lstate <= rplp_pkg::RPLP_L0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign hrdata        = st_ff.rdata;
  assign hreadyout     = 1'b1;
  assign hresp         = 1'b0;
  assign link.msg_vld  = st_ff.msg_vld;
  assign link.msg_code = st_ff.msg_code;
  assign link.msg_data = st_ff.msg_data;
  assign link.training = (st_ff.lstate == rplp_pkg::RPLP_LTRAIN);
  assign link.link_up  = (st_ff.lstate == rplp_pkg::RPLP_L0);
endmodule : rplp_port

// ==== design/rplp_train.sv ====
// Training timer; counts fixed cycles after start
module rplp_train (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic start,
  output logic      done
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       busy;
    logic       done;
  } rplp_train_st_t;

  rplp_train_st_t st_ff;
  rplp_train_st_t nxt_st;

  // Count down while busy
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.done = 1'b0;
    if (start) begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt  = rplp_pkg::TRAIN_CYCLES;
    end else if (st_ff.busy) begin
      if (st_ff.cnt == 4'h1) begin
        nxt_st.busy = 1'b0;
        nxt_st.done = 1'b1;
      end
      nxt_st.cnt = st_ff.cnt - 4'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) st_ff <= '0;
    else          st_ff <= nxt_st;
  end

  assign done = st_ff.done;
endmodule : rplp_train

// ==== dv/pcie_root_port_link_pm_tb.sv ====
////////////////////////////////////////
module pcie_root_port_link_pm_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize, dstate;
  logic [31:0] hwdata, hrdata, rd;
  logic        cmd_enable, wake_req, pme_req, active, ctx_lost;
  logic [9:0]  power_limit;
  logic [15:0] lfsr;
  logic [9:0]  lim_q[$];  // Model: limits owed on the link
  int          error_cnt, n_compared;
  rplp_link_if link ();

  rplp_port i_rplp_port (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .link(link));
  rplp_dev i_rplp_dev (.hclk(hclk), .hresetn(hresetn),
    .cmd_enable(cmd_enable), .wake_req(wake_req), .pme_req(pme_req),
    .dstate(dstate), .active(active), .ctx_lost(ctx_lost),
    .power_limit(power_limit), .link(link));
  rplp_link_asserts i_rplp_link_asserts (.hclk(hclk), .hresetn(hresetn),
    .msg_vld(link.msg_vld), .msg_code(link.msg_code),
    .msg_data(link.msg_data), .training(link.training),
    .link_up(link.link_up), .l1_exit_dn(link.l1_exit_dn),
    .l1_req(link.l1_req), .l23_ack(link.l23_ack));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Bounded wait for hready; a hang ends the run
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      finish_test();
    end
  endtask

  // Single word transfer: address phase, then data phase
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask

  task automatic rdm(input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask

  // Poll the link state under a bound
  task automatic wait_st(input logic [2:0] s);
    int n;
    n = 0;
    do begin
      ahb(1'b0, rplp_pkg::REG_STAT, 32'h0);
      n++;
    end while (rd[2:0] !== s && n < 60);
    chk({29'h0, rd[2:0]}, {29'h0, s});
    if (rd[2:0] !== s)
      finish_test();
  endtask

  function automatic logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // Every limit message must match the model queue
  always @(posedge hclk)
    if (link.msg_vld === 1'b1 && link.msg_code == rplp_pkg::RPLP_MSG_LIMIT)
      chk({22'h0, link.msg_data}, {22'h0, lim_q.pop_front()});

  initial begin
    #400000;
    error_cnt++;
    finish_test();
  end

  ////////////////////////////////////////
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
    {cmd_enable, wake_req, pme_req} = '0;
    lfsr = 16'h6316;
    error_cnt = 0;
    n_compared = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rdm(rplp_pkg::REG_STAT, 32'hF, 32'h0);
    rdm(rplp_pkg::REG_LAT, 32'h1FF, 32'h35);
    chk({22'h0, power_limit}, 32'hA);
    chk({29'h0, dstate}, 32'h0);
    chk({31'h0, active}, 32'h0);
    // ASPM enable attempt must change nothing
    ahb(1'b1, rplp_pkg::REG_CTRL, 32'h3);
    repeat (20) @(posedge hclk);
    rdm(rplp_pkg::REG_CTRL, 32'h3, 32'h0);
    rdm(rplp_pkg::REG_STAT, 32'h7, 32'h0);
    $display("done: reset and aspm");
    // Common clock plus retrain shortens reported latency
    ahb(1'b1, rplp_pkg::REG_CTRL, 32'h1F);
    @(posedge hclk);
    rdm(rplp_pkg::REG_STAT, 32'h7, 32'h5);
    wait_st(rplp_pkg::RPLP_L0);
    rdm(rplp_pkg::REG_CTRL, 32'hF, 32'hC);
    rdm(rplp_pkg::REG_LAT, 32'h1FF, 32'h12);
    $display("done: clocking");
    repeat (4) begin
      lfsr = nxt(lfsr);
      lim_q.push_back(lfsr[9:0]);
      ahb(1'b1, rplp_pkg::REG_LIMIT, {22'h0, lfsr[9:0]});
      repeat (3) @(posedge hclk);
      chk({22'h0, power_limit}, {22'h0, lfsr[9:0]});
      rdm(rplp_pkg::REG_LIMIT, 32'h3FF, {22'h0, lfsr[9:0]});
    end
    chk(32'(lim_q.size()), 32'h0);
    $display("done: power limit");
    cmd_enable <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({31'h0, active}, 32'h1);
    // Each low state; odd ones exit from above, even from below
    for (int d = 1; d < 5; d++) begin
      ahb(1'b1, rplp_pkg::REG_DSTATE, 32'(d));
      wait_st(rplp_pkg::RPLP_L1);
      chk({29'h0, dstate}, 32'(d));
      chk({31'h0, ctx_lost}, 32'(d >= 3));
      // Back to D0 first, else the device asks for L1 again at once
      ahb(1'b1, rplp_pkg::REG_DSTATE, 32'h0);
      if (d % 2 == 1)
        ahb(1'b1, rplp_pkg::REG_CTRL, 32'h104);
      else begin
        wake_req <= 1'b1;
        @(posedge hclk);
        wake_req <= 1'b0;
      end
      wait_st(rplp_pkg::RPLP_L0);
    end
    ahb(1'b1, rplp_pkg::REG_DSTATE, 32'h5);
    rdm(rplp_pkg::REG_DSTATE, 32'h7, 32'h0);
    $display("done: device states");
    // Power removal with aux power, then without
    for (int v = 1; v >= 0; v--) begin
      ahb(1'b1, rplp_pkg::REG_CTRL, v ? 32'h64 : 32'h24);
      wait_st(v ? rplp_pkg::RPLP_L2 : rplp_pkg::RPLP_L3);
      wake_req <= 1'b1;
      repeat (20) @(posedge hclk);
      wake_req <= 1'b0;
      rdm(rplp_pkg::REG_STAT, 32'h7, v ? 32'h3 : 32'h4);
      ahb(1'b1, rplp_pkg::REG_CTRL, 32'h84);
      wait_st(rplp_pkg::RPLP_L0);
    end
    $display("done: power removal");
    // Sticky event flag clears on read; hole reads zero
    pme_req <= 1'b1;
    @(posedge hclk);
    pme_req <= 1'b0;
    repeat (4) @(posedge hclk);
    rdm(rplp_pkg::REG_STAT, 32'h10, 32'h10);
    rdm(rplp_pkg::REG_STAT, 32'h10, 32'h0);
    rdm(8'h20, 32'hFFFF_FFFF, 32'h0);
    $display("done: event flag");
    finish_test();
  end
endmodule // pcie_root_port_link_pm_tb

// ==== dv/rplp_link_asserts.sv ====
////////////////////////////////////////
// Link-side checks between port and device ends
module rplp_link_asserts (
  input wire logic                hclk,
  input wire logic                hresetn,
  input wire logic                msg_vld,
  input wire rplp_pkg::rplp_msg_t msg_code,
  input wire logic [9:0]          msg_data,
  input wire logic                training,
  input wire logic                link_up,
  input wire logic                l1_exit_dn,
  input wire logic                l1_req,
  input wire logic                l23_ack
);
  // One clock domain, so one default clocking
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  ////////////////////////////////////////
  // Training run length; start pulse and done add two cycles to the timer
  localparam logic [4:0] TRN_LEN = 5'(rplp_pkg::TRAIN_CYCLES) + 5'h02;
  logic [4:0] trn_cnt_ff;
  logic       off_seen_ff;  // Power-off sent; no in-band exit until retrain

  // Helper counters; a repetition of ten would exceed the unroll limit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trn_cnt_ff  <= 5'h00;
      off_seen_ff <= 1'b0;
    end else begin
      trn_cnt_ff <= training ? trn_cnt_ff + 5'h01 : 5'h00;
      if (msg_vld && msg_code == rplp_pkg::RPLP_MSG_OFF) begin
        off_seen_ff <= 1'b1;
      end else if (training) begin
        off_seen_ff <= 1'b0;
      end
    end
  end

  property p_off_ack;
    msg_vld && msg_code == rplp_pkg::RPLP_MSG_OFF |=> l23_ack;
  endproperty
  a_off_ack: assert property (p_off_ack) else $error("no ack");
  property p_l23_down;
    l23_ack |-> ##[0:3] !link_up;
  endproperty
  a_l23_down: assert property (p_l23_down) else $error("l23");
  property p_l1_enter;
    l1_req && link_up |-> ##[1:4] !link_up;
  endproperty
  a_l1_enter: assert property (p_l1_enter) else $error("l1");
  // Link may only drop for a request, a message or training
  property p_no_auto;
    $fell(link_up) |-> training || $past(training) || msg_vld ||
      $past(msg_vld) || $past(msg_vld, 2) || $past(l1_req) ||
      $past(l1_req, 2) || $past(l23_ack) || $past(l23_ack, 2);
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("auto");
  property p_train_len;
    $fell(training) |-> trn_cnt_ff == TRN_LEN;
  endproperty
  a_train_len: assert property (p_train_len) else $error("trn");
  property p_train_up;
    $fell(training) |-> ##[0:2] link_up;
  endproperty
  a_train_up: assert property (p_train_up) else $error("up");
  // After power-off the device cannot wake the link in-band
  property p_exit_dn;
    l1_exit_dn && !off_seen_ff |-> ##[1:20] link_up;
  endproperty
  a_exit_dn: assert property (p_exit_dn) else $error("exit");
  property p_dset;
    msg_vld && msg_code == rplp_pkg::RPLP_MSG_DSET |-> msg_data <= 10'h004;
  endproperty
  a_dset: assert property (p_dset) else $error("dset");
endmodule // rplp_link_asserts
